/* File: src/sac_ctrl.sv */
// Successive approximation conversion sequencer with result FIFO
//
// How it works
// - Each conversion yields a 12-bit code; starts stay under 700 ksps.
// - After sampling, the search decides one bit per cycle, MSB to LSB.
// - A start pulse or a frame-start trigger edge begins a conversion.
// - In continuous mode the trigger is not needed and may be left low.
// - Starts wait 10 us after reset or wake; early ones are dropped.
// - Completion sets done, held high until the result is read.
// - A single bit picks one conversion per trigger, else continuous.
// - Results queue in a FIFO so DMA drains them without CPU help.
`timescale 1ns/1ps
module sac_ctrl (
    // Clock and reset
    input  wire logic                         clock_i,
    input  wire logic                         rst_i,
    // Control
    input  wire logic                         enable_i,
    input  wire logic                         start_i,
    input  wire logic                         single_i,
    input  wire logic                         frame_start_i,
    // Comparator and DAC
    input  wire logic                         cmp_i,
    output logic [sac_pkg::RES_BITS-1:0]      dac_code_o,
    output logic                              sample_o,
    // Result read port
    input  wire logic                         rd_i,
    output logic [sac_pkg::RES_BITS-1:0]      result_o,
    output logic                              done_o,
    // Status
    output logic                              ready_o,
    output logic                              busy_o,
    output logic                              overrun_o
);
    localparam int N = sac_pkg::RES_BITS;
    localparam int W = sac_pkg::CNT_W;

    // ------------------------------------------------------------------
    // Trigger input
    // ------------------------------------------------------------------
    logic trig_lvl_w;
    logic trig_d_r;

    sac_sync3 u_trig (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .async_i (frame_start_i),
        .level_o (trig_lvl_w)
    );

    wire trig_edge_w = trig_lvl_w && !trig_d_r;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    sac_pkg::sac_state_t state_r;
    sac_pkg::sac_state_t state_nxt;
    logic [W-1:0]        wait_r;
    logic [W-1:0]        period_r;
    logic [3:0]          bit_r;
    logic [N-1:0]        sar_r;
    logic [N-1:0]        result_r;
    logic                done_r;
    logic                ovr_r;
    logic                en_d_r;
    logic                pend_r;

    // FIFO wiring
    logic                fifo_in_rdy_w;
    logic                fifo_out_vld_w;
    logic [N-1:0]        fifo_out_w;
    logic [$clog2(sac_pkg::FIFO_DEPTH+1)-1:0] level_w;

    wire wake_w    = enable_i && !en_d_r;
    wire pwr_ok_w  = (wait_r == W'(sac_pkg::PWRUP_CYCLES));
    wire period_ok = (period_r >= W'(sac_pkg::MIN_PERIOD_CYC));
    wire req_w     = start_i || trig_edge_w || pend_r;
    // continuous self restart, no trigger needed
    wire go_w      = enable_i && (single_i ? req_w : 1'b1);
    wire last_w    = (bit_r == 4'h0);
    wire store_w   = (state_r == sac_pkg::SAC_STORE);
    wire push_w    = store_w && fifo_in_rdy_w;
    wire pop_w     = rd_i && fifo_out_vld_w;
    // trial bit set at current position
    wire [N-1:0] trial_w = sar_r | (N'(1) << bit_r);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            sac_pkg::SAC_POWERUP: begin
                if (pwr_ok_w) begin
                    state_nxt = sac_pkg::SAC_IDLE;
                end
            end
            sac_pkg::SAC_IDLE: begin
                if (go_w && period_ok) begin
                    state_nxt = sac_pkg::SAC_SAMPLE;
                end
            end
            sac_pkg::SAC_SAMPLE: begin
                state_nxt = sac_pkg::SAC_SEARCH;
            end
            sac_pkg::SAC_SEARCH: begin
                if (last_w) begin
                    state_nxt = sac_pkg::SAC_STORE;
                end
            end
            sac_pkg::SAC_STORE: begin
                // FIFO full stalls the sequencer instead of dropping data
                if (fifo_in_rdy_w) begin
                    state_nxt = sac_pkg::SAC_IDLE;
                end
            end
            default: begin
                state_nxt = sac_pkg::SAC_IDLE;
            end
        endcase
        if (!enable_i) begin
            state_nxt = sac_pkg::SAC_POWERUP;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_r  <= sac_pkg::SAC_POWERUP;
            trig_d_r <= 1'b0;
            en_d_r   <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            trig_d_r <= trig_lvl_w;
            en_d_r   <= enable_i;
        end
    end

    // settling counter, restarted on every wake
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wait_r <= sac_pkg::CNT_RST;
        end else if (!enable_i || wake_w) begin
            wait_r <= sac_pkg::CNT_RST;
        end else if (!pwr_ok_w) begin
            wait_r <= W'(wait_r + 1'b1);
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            period_r <= W'(sac_pkg::MIN_PERIOD_CYC);
        end else if (state_r == sac_pkg::SAC_IDLE && go_w && period_ok) begin
            period_r <= W'(1);
        end else if (!period_ok) begin
            period_r <= W'(period_r + 1'b1);
        end
    end

    // one conversion per request; a request that comes while busy
    // is held once, an early one before settling is dropped
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pend_r <= 1'b0;
        end else if (state_r == sac_pkg::SAC_IDLE && go_w && period_ok) begin
            pend_r <= 1'b0;
        end else if (state_r != sac_pkg::SAC_POWERUP && single_i
                     && (start_i || trig_edge_w)) begin
            pend_r <= 1'b1;
        end else if (!single_i || state_r == sac_pkg::SAC_POWERUP) begin
            pend_r <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            bit_r <= 4'h0;
            sar_r <= sac_pkg::RESULT_RST;
        end else if (state_r == sac_pkg::SAC_SAMPLE) begin
            bit_r <= 4'(N - 1);
            sar_r <= sac_pkg::RESULT_RST;
        end else if (state_r == sac_pkg::SAC_SEARCH) begin
            sar_r <= cmp_i ? trial_w : sar_r;
            bit_r <= last_w ? 4'h0 : 4'(bit_r - 1'b1);
        end
    end

    // ------------------------------------------------------------------
    // Result queue
    // ------------------------------------------------------------------
    // results queue for DMA drain
    sac_fifo #(
        .WIDTH (N),
        .DEPTH (sac_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .in_valid_i  (store_w),
        .in_ready_o  (fifo_in_rdy_w),
        .in_data_i   (sar_r),
        .out_valid_o (fifo_out_vld_w),
        .out_ready_i (rd_i),
        .out_data_o  (fifo_out_w),
        .level_o     (level_w)
    );

    // done held while unread results remain; a push beats a read
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            done_r   <= 1'b0;
            result_r <= sac_pkg::RESULT_RST;
            ovr_r    <= 1'b0;
        end else begin
            done_r   <= push_w || (level_w > (pop_w ? 1 : 0));
            result_r <= fifo_out_w;
            if (store_w && !fifo_in_rdy_w) begin
                ovr_r <= 1'b1;
            end else if (pop_w) begin
                ovr_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    logic [N-1:0] dac_r;
    logic         sample_r;
    logic         ready_r;
    logic         busy_r;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            dac_r    <= sac_pkg::RESULT_RST;
            sample_r <= 1'b0;
            ready_r  <= 1'b0;
            busy_r   <= 1'b0;
        end else begin
            dac_r    <= (state_nxt == sac_pkg::SAC_SEARCH)
                        ? ((state_r == sac_pkg::SAC_SEARCH)
                           ? ((cmp_i ? trial_w : sar_r)
                              | (N'(1) << 4'(bit_r - 1'b1)))
                           : (N'(1) << (N - 1)))
                        : sar_r;
            sample_r <= (state_nxt == sac_pkg::SAC_SAMPLE);
            ready_r  <= (state_nxt != sac_pkg::SAC_POWERUP);
            busy_r   <= (state_nxt == sac_pkg::SAC_SAMPLE)
                        || (state_nxt == sac_pkg::SAC_SEARCH)
                        || (state_nxt == sac_pkg::SAC_STORE);
        end
    end

    assign dac_code_o = dac_r;
    assign sample_o   = sample_r;
    assign result_o   = result_r;
    assign done_o     = done_r;
    assign ready_o    = ready_r;
    assign busy_o     = busy_r;
    assign overrun_o  = ovr_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_pwrup;
        @(posedge clock_i) disable iff (rst_i)
        (state_r != sac_pkg::SAC_POWERUP
         && $past(state_r) == sac_pkg::SAC_POWERUP)
        |-> $past(wait_r) == W'(sac_pkg::PWRUP_CYCLES);
    endproperty
    a_pwrup: assert property (p_pwrup)
        else $error("left power-up wait early");

    property p_search_len;
        @(posedge clock_i) disable iff (rst_i || !enable_i)
        (state_r == sac_pkg::SAC_SAMPLE)
        |=> (state_r == sac_pkg::SAC_SEARCH)
        ##11 (state_r == sac_pkg::SAC_SEARCH)
        ##1 (state_r == sac_pkg::SAC_STORE);
    endproperty
    a_search_len: assert property (p_search_len)
        else $error("search not twelve cycles");

    property p_done;
        @(posedge clock_i) disable iff (rst_i)
        push_w |=> done_o;
    endproperty
    a_done: assert property (p_done)
        else $error("done not raised after result");

    property p_done_hold;
        @(posedge clock_i) disable iff (rst_i)
        (done_o && !rd_i && level_w != 0) |=> done_o;
    endproperty
    a_done_hold: assert property (p_done_hold)
        else $error("done dropped before read");

    property p_cont;
        @(posedge clock_i) disable iff (rst_i)
        (enable_i && !single_i && state_r == sac_pkg::SAC_IDLE)
        |-> ##[0:15] (state_r == sac_pkg::SAC_SAMPLE || !enable_i
                      || single_i);
    endproperty
    a_cont: assert property (p_cont)
        else $error("continuous mode did not restart");

    property p_single;
        @(posedge clock_i) disable iff (rst_i)
        (state_r == sac_pkg::SAC_IDLE && single_i && !req_w)
        |=> state_r != sac_pkg::SAC_SAMPLE;
    endproperty
    a_single: assert property (p_single)
        else $error("single mode started without request");

    property p_rate;
        @(posedge clock_i) disable iff (rst_i)
        (state_r == sac_pkg::SAC_SAMPLE) |-> $past(period_ok);
    endproperty
    a_rate: assert property (p_rate)
        else $error("start spacing below rate limit");

    property p_start;
        @(posedge clock_i) disable iff (rst_i)
        (state_r == sac_pkg::SAC_IDLE && enable_i && start_i && period_ok)
        |=> state_r == sac_pkg::SAC_SAMPLE;
    endproperty
    a_start: assert property (p_start)
        else $error("start pulse ignored");

endmodule : sac_ctrl

/* File: src/sac_pkg.sv */
// Shared constants and types for the successive approximation control block
package sac_pkg;

    // ------------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------------
    localparam int          RES_BITS      = 12;
    localparam int          FIFO_DEPTH    = 16;
    localparam int          CLK_HZ        = 10_000_000;
    localparam int          CLK_PERIOD_NS = 100;
    localparam int          MAX_CLK_HZ    = 14_000_000;
    localparam int          MAX_RATE_SPS  = 700_000;
    localparam int          PWRUP_WAIT_US = 10;
    localparam int          PWRUP_CYCLES  =
        (PWRUP_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Shortest spacing between starts that keeps under the rate limit
    localparam int          MIN_PERIOD_CYC =
        (CLK_HZ + MAX_RATE_SPS - 1) / MAX_RATE_SPS;
    localparam int          SAMPLE_CYCLES = 1;
    localparam int          CNT_W         = 11;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [RES_BITS-1:0] RESULT_RST = 12'h000;
    localparam logic [CNT_W-1:0]    CNT_RST    = 11'h000;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SAC_POWERUP,
        SAC_IDLE,
        SAC_SAMPLE,
        SAC_SEARCH,
        SAC_STORE,
        SAC_GAP
    } sac_state_t;

endpackage : sac_pkg

/* File: src/sac_fifo.sv */
// Result FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sac_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clock_i,
    input  wire logic             rst_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o,
    // Status
    output logic [$clog2(DEPTH+1)-1:0] level_o
);
    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [LW-1:0]    level_r;
    wire              push_w = in_valid_i && in_ready_o;
    wire              pop_w  = out_valid_o && out_ready_i;

    assign in_ready_o  = (level_r != LW'(DEPTH));
    assign out_valid_o = (level_r != '0);
    assign out_data_o  = mem[rd_ptr_r];
    assign level_o     = level_r;

    always_ff @(posedge clock_i) begin
        if (push_w) begin
            mem[wr_ptr_r] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            level_r  <= '0;
        end else begin
            if (push_w) begin
                wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
            end
            if (pop_w) begin
                rd_ptr_r <= AW'(rd_ptr_r + 1'b1);
            end
            level_r <= LW'(level_r + LW'(push_w) - LW'(pop_w));
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_no_overfill;
        @(posedge clock_i) disable iff (rst_i)
        (level_r == LW'(DEPTH)) |-> !in_ready_o && (wr_ptr_r == rd_ptr_r);
    endproperty
    a_no_overfill: assert property (p_no_overfill)
        else $error("fifo accepts while full");

endmodule : sac_fifo

/* File: src/sac_sync3.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module sac_sync3 (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic rst_i,
    // Signal
    input  wire logic async_i,
    output logic      level_o
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_r;

    assign level_o = level_r;

    // Stage one feeds stage two only; the filter looks at stages 2 and 3
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            s1_r    <= 1'b0;
            s2_r    <= 1'b0;
            s3_r    <= 1'b0;
            level_r <= 1'b0;
        end else begin
            s1_r <= async_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_r <= s3_r;
            end
        end
    end

endmodule : sac_sync3

/* File: bench/sac_cmp_model.sv */
// Sample-and-hold plus comparator model facing the sequencer
`timescale 1ns/1ps
module sac_cmp_model (
    // Clock
    input  wire logic                         clock_i,
    // Sequencer side
    input  wire logic                         sample_i,
    input  wire logic [sac_pkg::RES_BITS-1:0] dac_code_i,
    output logic                              cmp_o,
    // Analog input as a code
    input  wire logic [sac_pkg::RES_BITS-1:0] level_i
);
    // -------------------------------------------------------------------
    // Hold and compare
    // -------------------------------------------------------------------
    logic [sac_pkg::RES_BITS-1:0] held_r = 12'h000;

    // Input is frozen at the sample cycle, so later changes are not seen
    always @(posedge clock_i) begin
        if (sample_i) begin
            held_r <= level_i;
        end
    end

    assign cmp_o = (dac_code_i <= held_r);
endmodule : sac_cmp_model

/* File: bench/sar_adc_conversion_control_tb.sv */
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`define CHECK(act, exp) begin \
    samples_checked++; \
    if ((act) !== (exp)) begin \
        fail_count++; \
        $display("wrong value at %0t: got %h expected %h", \
                 $time, act, exp); \
    end \
end
module sar_adc_conversion_control_tb;
    // -------------------------------------------------------------------
    // Signals
    // -------------------------------------------------------------------
    logic                         clock_i  = 1'b0;
    logic                         rst_i    = 1'b1;
    logic                         enable_i = 1'b1;
    logic                         start_i  = 1'b0;
    logic                         single_i = 1'b1;
    logic                         frame_start_i = 1'b0;
    logic                         rd_i     = 1'b0;
    logic                         cmp;
    logic                         sample;
    logic [sac_pkg::RES_BITS-1:0] dac_code;
    logic [sac_pkg::RES_BITS-1:0] result_o;
    logic [sac_pkg::RES_BITS-1:0] level    = 12'h000;
    logic                         done_o;
    logic                         ready_o;
    logic                         busy_o;
    logic                         overrun_o;
    int                           fail_count = 0;
    int                           samples_checked = 0;
    int                           cycle_count = 0;
    int                           i;
    logic [sac_pkg::RES_BITS-1:0] codes [5] =
        '{12'h000, 12'hFFF, 12'h800, 12'h7FF, 12'hA5A};

    // 10 MHz keeps the sequencer clock under its ceiling
    always #50 clock_i = ~clock_i;

    sac_ctrl i_dut (
        .clock_i       (clock_i),
        .rst_i         (rst_i),
        .enable_i      (enable_i),
        .start_i       (start_i),
        .single_i      (single_i),
        .frame_start_i (frame_start_i),
        .cmp_i         (cmp),
        .dac_code_o    (dac_code),
        .sample_o      (sample),
        .rd_i          (rd_i),
        .result_o      (result_o),
        .done_o        (done_o),
        .ready_o       (ready_o),
        .busy_o        (busy_o),
        .overrun_o     (overrun_o)
    );

    sac_cmp_model i_cmp (
        .clock_i    (clock_i),
        .sample_i   (sample),
        .dac_code_i (dac_code),
        .cmp_o      (cmp),
        .level_i    (level)
    );

    // -------------------------------------------------------------------
    // Tasks
    // -------------------------------------------------------------------
    task automatic give_verdict();
        $display("checked %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    task automatic tick(input int n);
        repeat (n) @(negedge clock_i);
    endtask : tick

    task automatic wait_done();
        int k;
        for (k = 0; k < 40 && done_o !== 1'b1; k++) begin
            tick(1);
        end
        `CHECK(done_o, 1'b1)
    endtask : wait_done

    // Head shows one cycle after done; pop, then let it settle
    task automatic read_word(input logic [sac_pkg::RES_BITS-1:0] exp);
        tick(1);
        `CHECK(result_o, exp)
        rd_i = 1'b1;
        tick(1);
        rd_i = 1'b0;
        tick(1);
    endtask : read_word

    task automatic pulse_start();
        start_i = 1'b1;
        tick(1);
        start_i = 1'b0;
    endtask : pulse_start

    task automatic wait_ready();
        int k;
        for (k = 0; k < 20 && ready_o !== 1'b1; k++) begin
            tick(1);
        end
        `CHECK(ready_o, 1'b1)
    endtask : wait_ready

    // Hang guard: whole run needs about 700 cycles
    always @(posedge clock_i) begin
        cycle_count++;
        if (cycle_count == 6000) begin
            fail_count++;
            give_verdict();
        end
    end

    // -------------------------------------------------------------------
    // Tests
    // -------------------------------------------------------------------
    initial begin
        tick(6);
        rst_i = 1'b0;
        tick(50);
        pulse_start();
        tick(40);
        `CHECK(ready_o, 1'b0)
        `CHECK(busy_o, 1'b0)
        `CHECK(done_o, 1'b0)
        wait_ready();
        $display("test power_up done");

        for (i = 0; i < 5; i++) begin
            level = codes[i];
            pulse_start();
            `CHECK(busy_o, 1'b1)
            `CHECK(sample, 1'b1)
            tick(1);
            `CHECK(dac_code, 12'h800)
            wait_done();
            read_word(codes[i]);
            `CHECK(done_o, 1'b0)
        end
        level = 12'h3C3;
        pulse_start();
        tick(3);
        pulse_start();
        wait_done();
        read_word(12'h3C3);
        wait_done();
        read_word(12'h3C3);
        `CHECK(done_o, 1'b0)
        $display("test start_bit done");

        // Trigger held high must yield exactly one conversion
        level = 12'h5A5;
        frame_start_i = 1'b1;
        wait_done();
        read_word(12'h5A5);
        tick(60);
        `CHECK(done_o, 1'b0)
        `CHECK(busy_o, 1'b0)
        frame_start_i = 1'b0;
        tick(5);
        level = 12'h123;
        frame_start_i = 1'b1;
        wait_done();
        read_word(12'h123);
        frame_start_i = 1'b0;
        $display("test trigger done");

        // One start, no trigger: results pile up until the FIFO is full
        single_i = 1'b0;
        level = 12'h9B6;
        pulse_start();
        for (i = 0; i < 1000 && overrun_o !== 1'b1; i++) begin
            tick(1);
        end
        `CHECK(overrun_o, 1'b1)
        `CHECK(done_o, 1'b1)
        for (i = 0; i < 4; i++) begin
            read_word(12'h9B6);
        end
        `CHECK(overrun_o, 1'b0)
        $display("test continuous done");

        enable_i = 1'b0;
        tick(5);
        `CHECK(ready_o, 1'b0)
        enable_i = 1'b1;
        tick(90);
        `CHECK(ready_o, 1'b0)
        wait_ready();
        $display("test wake done");
        give_verdict();
    end
endmodule : sar_adc_conversion_control_tb
